// [lsl_pkg.sv]
/*
 logical left shift unit package: operation codes, field positions, widths,
 reset values and the operand/flag carriers.
 assumes a single core clock; no bus, all control is by plain ports.
*/
// Functional notes
// - immediate shift of sum register by 1..16, zero fill, last out to carry
// - immediate sum shift: sign flag from result bit 31
// - immediate sum shift: zero flag when whole 32-bit result is zero
// - immediate sum shift repeats N+1 times; flags show final result only
// - register-count sum shift uses count bits 3:0, range 0..15, one cycle
// - register-count sum shift: zero count clears carry, else last bit out
// - zero register count still updates zero and sign from sum register
// - immediate half shift on upper or lower word, 1..16, zero fill
// - immediate half shift: carry last out, sign bit 15, zero on half
// - register-count half shift uses bits 3:0; zero count clears carry
// - zero register count on half still updates zero and sign flags
// - immediate wide shift of sum:product pair by 1..16, last out to carry
// - wide shift: sign from sum bit 31, zero when all 64 bits zero
// - register-count wide shift takes count from six low bits
// - wide register count 0..63; zero count clears carry, else last out
package lsl_pkg;
   localparam int LSL_W = 32;
   localparam int LSL_HW = 16;
   localparam int LSL_CW = 6;
   localparam int LSL_RW = 16;
   localparam logic [LSL_CW-1:0] LSL_MASK4 = 6'h0f;
   localparam logic [LSL_CW-1:0] LSL_MASK6 = 6'h3f;
   localparam logic [LSL_CW-1:0] LSL_ZERO_CNT = 6'h00;
   localparam logic [LSL_RW-1:0] LSL_RPT_RST = 16'h0000;
   localparam logic [LSL_RW-1:0] LSL_RPT_ONE = 16'h0001;
   localparam int LSL_SIGN32 = 31;
   localparam int LSL_SIGN16 = 15;

   typedef enum logic [2:0] {
      LSL_OP_ACC_IMM,
      LSL_OP_ACC_REG,
      LSL_OP_HALF_IMM,
      LSL_OP_HALF_REG,
      LSL_OP_WIDE_IMM,
      LSL_OP_WIDE_REG
   } lsl_op_e;

   typedef struct packed {
      lsl_op_e op;
      logic upper_sel;
      logic [3:0] shift_amount_field;
      logic [LSL_RW-1:0] multiplicand_pair;
   } lsl_cmd_s;

   typedef struct packed {
      logic sign;
      logic zero;
      logic carry;
   } lsl_flags_s;
endpackage

// [lsl_unit.sv]
/*
 logical left shift unit: shifts the sum register, one of its halves, or the
 sum:product pair, updates sign/zero/carry, and runs the repeat prefix.
 assumes commands arrive synchronous to clk_in, one per cycle when idle.
*/
`timescale 1ns/10ps
`default_nettype none
module lsl_unit
   import lsl_pkg::*;
#(
   parameter int RPT_W = LSL_RW
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cmd_valid_in,
   input wire lsl_cmd_s cmd_in,
   input wire logic repeat_prefix_in,
   input wire logic [RPT_W-1:0] repeat_count_in,
   input wire logic load_in,
   input wire logic [LSL_W-1:0] sum_load_in,
   input wire logic [LSL_W-1:0] product_load_in,
   output logic [LSL_W-1:0] sum_register_out,
   output logic [LSL_W-1:0] product_out,
   output lsl_flags_s flags_out,
   output logic [RPT_W-1:0] repeat_counter_out,
   output logic busy_out
);
   typedef enum logic {LSL_IDLE, LSL_REPEAT} lsl_state_e;

   // shifter geometry: each operand sits at the top of a double-width word, so
   // the last bit pushed out always lands in the one bit above it
   localparam int LSL_DW = 2 * LSL_W;
   localparam int LSL_HI_LSB = LSL_DW - LSL_W;
   localparam int LSL_HALF_LSB = LSL_DW - LSL_HW;
   localparam logic [LSL_CW-1:0] LSL_IMM_BIAS = 6'h01;
   localparam logic [RPT_W-1:0] RPT_ZERO = LSL_RPT_RST[RPT_W-1:0];
   localparam logic [RPT_W-1:0] RPT_STEP = LSL_RPT_ONE[RPT_W-1:0];

   function automatic logic [LSL_DW:0] lsl_shift(
      input logic [LSL_DW-1:0] v,
      input logic [LSL_CW-1:0] n
   );
      logic [2*LSL_DW-1:0] wide;
      wide = {{LSL_DW{1'b0}}, v} << n;
      return wide[LSL_DW:0];
   endfunction

   // count sits in the low bits of the upper multiplier half; the rest is ignored
   function automatic logic [LSL_CW-1:0] lsl_low_count(
      input logic [LSL_RW-1:0] t,
      input logic [LSL_CW-1:0] mask
   );
      return t[LSL_CW-1:0] & mask;
   endfunction

   function automatic logic [LSL_HW-1:0] lsl_pick_half(
      input logic [LSL_W-1:0] v,
      input logic upper
   );
      return upper ? v[LSL_W-1:LSL_HW] : v[LSL_HW-1:0];
   endfunction

   // the half that is not shifted keeps its bits
   function automatic logic [LSL_W-1:0] lsl_put_half(
      input logic [LSL_W-1:0] v,
      input logic [LSL_HW-1:0] h,
      input logic upper
   );
      return upper ? {h, v[LSL_HW-1:0]} : {v[LSL_W-1:LSL_HW], h};
   endfunction

   lsl_state_e state;
   logic busy;
   logic [LSL_W-1:0] sum_register;
   logic [LSL_W-1:0] product;
   lsl_flags_s flags;
   logic [RPT_W-1:0] repeat_counter;
   lsl_cmd_s held;
   logic [LSL_CW-1:0] cnt;

   // while repeating the stored command is replayed; the input bus may change
   wire lsl_cmd_s cur = (state == LSL_REPEAT) ? held : cmd_in;
   wire logic repeating = (state == LSL_REPEAT);
   wire logic is_half = (cur.op == LSL_OP_HALF_IMM) || (cur.op == LSL_OP_HALF_REG);
   wire logic is_wide = (cur.op == LSL_OP_WIDE_IMM) || (cur.op == LSL_OP_WIDE_REG);
   wire logic is_reg = (cur.op == LSL_OP_ACC_REG) || (cur.op == LSL_OP_HALF_REG)
                       || (cur.op == LSL_OP_WIDE_REG);

   // the immediate field holds the count minus one: 4'h0 shifts by 1, 4'hf by 16
   wire logic [LSL_CW-1:0] imm_cnt = LSL_CW'(cur.shift_amount_field) + LSL_IMM_BIAS;
   wire logic [LSL_CW-1:0] reg4_cnt =
      lsl_low_count(cur.multiplicand_pair, LSL_MASK4);
   wire logic [LSL_CW-1:0] reg6_cnt =
      lsl_low_count(cur.multiplicand_pair, LSL_MASK6);
   always_comb begin
      case (cur.op)
         LSL_OP_ACC_REG, LSL_OP_HALF_REG: cnt = reg4_cnt;
         LSL_OP_WIDE_REG: cnt = reg6_cnt;
         default: cnt = imm_cnt;
      endcase
   end

   wire logic [LSL_HW-1:0] half_in = lsl_pick_half(sum_register, cur.upper_sel);
   wire logic [LSL_DW-1:0] pad_half = {half_in, {LSL_HALF_LSB{1'b0}}};
   wire logic [LSL_DW-1:0] pad_full = {sum_register, {LSL_HI_LSB{1'b0}}};
   wire logic [LSL_DW-1:0] pad_wide = {sum_register, product};
   wire logic [LSL_DW-1:0] operand = is_wide ? pad_wide : is_half ? pad_half : pad_full;
   wire logic [LSL_DW:0] shifted = lsl_shift(operand, cnt);
   wire logic shifted_out = shifted[LSL_DW];
   wire logic [LSL_W-1:0] res_hi = shifted[LSL_DW-1:LSL_HI_LSB];
   wire logic [LSL_HW-1:0] res_half = shifted[LSL_DW-1:LSL_HALF_LSB];
   wire logic [LSL_W-1:0] res_lo = shifted[LSL_HI_LSB-1:0];

   // a zero register count clears carry, but the flags still test the value
   wire logic zero_count = is_reg && (cnt == LSL_ZERO_CNT);
   wire logic next_carry = zero_count ? 1'b0 : shifted_out;
   wire logic sign_full = res_hi[LSL_SIGN32];
   wire logic sign_half = res_half[LSL_SIGN16];
   wire logic next_sign = is_half ? sign_half : sign_full;
   wire logic zero_full = (res_hi == '0);
   wire logic zero_half = (res_half == '0);
   wire logic zero_wide = (shifted[LSL_DW-1:0] == '0);
   wire logic next_zero = is_wide ? zero_wide : is_half ? zero_half : zero_full;
   wire lsl_flags_s next_flags = {next_sign, next_zero, next_carry};

   wire logic [LSL_W-1:0] half_merged = lsl_put_half(sum_register, res_half, cur.upper_sel);
   wire logic [LSL_W-1:0] next_sum = is_half ? half_merged : res_hi;
   wire logic [LSL_W-1:0] next_product = is_wide ? res_lo : product;

   wire logic start = (state == LSL_IDLE) && cmd_valid_in;
   wire logic exec = start || repeating;
   // only the immediate full-register form is repeatable; a zero count runs once
   wire logic start_rpt = start && repeat_prefix_in && (cmd_in.op == LSL_OP_ACC_IMM)
                          && (repeat_count_in != '0);
   wire logic rpt_done = repeating && (repeat_counter == RPT_STEP);
   wire logic [RPT_W-1:0] counter_less = repeat_counter - RPT_STEP;

   // busy is a flop of its own so the port comes straight from a register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= LSL_IDLE;
         busy <= 1'b0;
      end else begin
         case (state)
            LSL_IDLE: begin
               if (start_rpt) begin
                  state <= LSL_REPEAT;
                  busy <= 1'b1;
               end
            end
            LSL_REPEAT: begin
               if (rpt_done) begin
                  state <= LSL_IDLE;
                  busy <= 1'b0;
               end
            end
            default: begin
               state <= LSL_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // captured once, so a repeat cannot see a changed input
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         held <= '0;
      end else if (start_rpt) begin
         held <= cmd_in;
      end
   end

   // counts down from N; a command that cannot repeat clears it
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         repeat_counter <= RPT_ZERO;
      end else if (start_rpt) begin
         repeat_counter <= repeat_count_in;
      end else if (start) begin
         repeat_counter <= RPT_ZERO;
      end else if (repeating) begin
         repeat_counter <= counter_less;
      end
   end

   // direct loads are for software moves; a shift in flight wins over them
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sum_register <= '0;
      end else if (exec) begin
         sum_register <= next_sum;
      end else if (load_in) begin
         sum_register <= sum_load_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         product <= '0;
      end else if (exec) begin
         product <= next_product;
      end else if (load_in) begin
         product <= product_load_in;
      end
   end

   // flags change only on a shift, so a repeat leaves those of the last pass
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         flags <= '0;
      end else if (exec) begin
         flags <= next_flags;
      end
   end

   assign sum_register_out = sum_register;
   assign product_out = product;
   assign flags_out = flags;
   assign repeat_counter_out = repeat_counter;
   assign busy_out = busy;
endmodule
`default_nettype wire

// [lsl_unit_properties.sv]
/* checker for lsl_unit: shift results, flags and repeat counter.
 bound into every lsl_unit; one clock, async active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module lsl_unit_properties
   import lsl_pkg::*;
#(parameter int RPT_W = LSL_RW) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cmd_valid_in,
   input wire lsl_cmd_s cmd_in,
   input wire logic repeat_prefix_in,
   input wire logic [RPT_W-1:0] repeat_count_in,
   input wire logic [LSL_W-1:0] sum_register_out,
   input wire logic [LSL_W-1:0] product_out,
   input wire lsl_flags_s flags_out,
   input wire logic [RPT_W-1:0] repeat_counter_out,
   input wire logic busy_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   wire logic go = cmd_valid_in && !busy_out;
   wire lsl_op_e op = cmd_in.op;
   wire logic [3:0] cnt = cmd_in.multiplicand_pair[3:0];
   a_imm_shift: assert property (go && op == LSL_OP_ACC_IMM && !repeat_prefix_in
      && cmd_in.shift_amount_field != 4'h0 |=> sum_register_out ==
      $past(sum_register_out) << ($past(cmd_in.shift_amount_field) + 5'h1)) else $error("imm");
   a_reg_shift: assert property (go && op == LSL_OP_ACC_REG |=>
      sum_register_out == $past(sum_register_out) << $past(cnt)) else $error("reg shift");
   a_reg_zero: assert property (go && op == LSL_OP_ACC_REG && cnt == 4'h0 |=>
      !flags_out.carry && flags_out.zero == (sum_register_out == 32'h0)) else $error("zero cnt");
   a_half_keep: assert property (go && cmd_in.upper_sel && op inside {LSL_OP_HALF_IMM,
      LSL_OP_HALF_REG} |=> $stable(sum_register_out[15:0]) && $stable(product_out))
      else $error("half keep");
   a_wide_flags: assert property (go && op inside {LSL_OP_WIDE_IMM, LSL_OP_WIDE_REG} |=>
      flags_out.zero == ({sum_register_out, product_out} == 64'h0)
      && flags_out.sign == sum_register_out[31]) else $error("wide flags");
   a_rpt_busy: assert property (go && op == LSL_OP_ACC_IMM && repeat_prefix_in
      && repeat_count_in == 2 |=> busy_out [*2] ##1 !busy_out) else $error("repeat len");
   a_count_down: assert property (busy_out && repeat_counter_out != 0 |=>
      repeat_counter_out == $past(repeat_counter_out) - 1'b1) else $error("count down");
   a_rpt_clear: assert property (go && repeat_prefix_in && op != LSL_OP_ACC_IMM |=>
      repeat_counter_out == 0 && !busy_out) else $error("repeat clear");
endmodule
bind lsl_unit lsl_unit_properties #(.RPT_W(RPT_W)) chk_u (.clk_in, .rst_in, .cmd_valid_in,
   .cmd_in, .repeat_prefix_in, .repeat_count_in, .sum_register_out, .product_out, .flags_out,
   .repeat_counter_out, .busy_out);
`default_nettype wire

// [lsl_unit_bench.sv]
/* self-checking bench for lsl_unit: table of shifts, then repeat and reset.
 assumes lsl_pkg and the checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module lsl_unit_bench
   import lsl_pkg::*;
;
   typedef struct packed {
      lsl_cmd_s c;
      logic [31:0] s, p, es, ep;
      lsl_flags_s ef;
   } lsl_row_s;
   logic clk_in, rst_in, cmd_valid_in, repeat_prefix_in, load_in, busy_out;
   lsl_cmd_s cmd_in;
   logic [15:0] repeat_count_in, repeat_counter_out;
   logic [31:0] sum_load_in, product_load_in, sum_register_out, product_out;
   lsl_flags_s flags_out;
   int mismatches = 0;
   int samples_checked = 0;
   // zero-count rows follow a carry of one so the clear shows
   lsl_row_s rows [7] = '{
      '{'{LSL_OP_ACC_IMM, 1'b0, 4'he, 16'h0}, 32'h28000, 32'h0, 32'h40000000, 32'h0, 3'h1},
      '{'{LSL_OP_ACC_REG, 1'b0, 4'h0, 16'hfff0}, 32'h0, 32'h0, 32'h0, 32'h0, 3'h2},
      '{'{LSL_OP_ACC_REG, 1'b0, 4'h0, 16'hfff4}, 32'hf000000, 32'h0, 32'hf0000000, 32'h0, 3'h4},
      '{'{LSL_OP_HALF_IMM, 1'b1, 4'he, 16'h0}, 32'h21234, 32'h5, 32'h1234, 32'h5, 3'h3},
      '{'{LSL_OP_HALF_REG, 1'b0, 4'h0, 16'hfff0}, 32'h8000, 32'h0, 32'h8000, 32'h0, 3'h4},
      '{'{LSL_OP_WIDE_IMM, 1'b0, 4'he, 16'h0}, 32'h20001, 32'h20000, 32'h8001, 32'h0, 3'h1},
      '{'{LSL_OP_WIDE_REG, 1'b0, 4'h0, 16'h60}, 32'h0, 32'h80000001, 32'h80000001, 32'h0, 3'h4}};
   lsl_unit dut_u (.clk_in, .rst_in, .cmd_valid_in, .cmd_in, .repeat_prefix_in,
      .repeat_count_in, .load_in, .sum_load_in, .product_load_in, .sum_register_out,
      .product_out, .flags_out, .repeat_counter_out, .busy_out);
   task chk(input string n, input logic [63:0] e, input logic [63:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task go(input lsl_row_s r, input logic pre, input logic [15:0] n);
      @(posedge clk_in) #1 load_in = 1'b1;
      {sum_load_in, product_load_in} = {r.s, r.p};
      @(posedge clk_in) #1 load_in = 1'b0;
      {cmd_valid_in, cmd_in, repeat_prefix_in, repeat_count_in} = {1'b1, r.c, pre, n};
      @(posedge clk_in) #1 cmd_valid_in = 1'b0;
   endtask
   task res(input lsl_row_s r);
      chk("sum", r.es, sum_register_out);
      chk("product", r.ep, product_out);
      chk("flags", r.ef, flags_out);
   endtask
   task conclude;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      lsl_row_s x;
      {rst_in, cmd_valid_in, repeat_prefix_in, load_in} = 4'h8;
      {cmd_in, repeat_count_in, sum_load_in, product_load_in} = '0;
      repeat (20) @(posedge clk_in);
      #1 rst_in = 1'b0;
      chk("reset", 64'h0, {sum_register_out, flags_out, busy_out});
      foreach (rows[i]) begin
         go(rows[i], 1'b0, 16'h0);
         res(rows[i]);
      end
      x = '{'{LSL_OP_ACC_IMM, 1'b0, 4'h3, 16'h1}, 32'h100001, 32'h0, 32'h1000, 32'h0, 3'h1};
      go(x, 1'b1, 16'h2);
      // a command while busy must be dropped
      @(posedge clk_in) #1 {cmd_valid_in, cmd_in.op} = {1'b1, LSL_OP_ACC_REG};
      @(posedge clk_in) #1 cmd_valid_in = 1'b0;
      for (int k = 0; k < 8 && busy_out !== 1'b0; k++) @(posedge clk_in) #1;
      res(x);
      chk("counter busy", 64'h0, {repeat_counter_out, busy_out});
      x = '{'{LSL_OP_WIDE_IMM, 1'b0, 4'h3, 16'h0}, 32'h0, 32'h80000000, 32'h8, 32'h0, 3'h0};
      go(x, 1'b1, 16'h5);
      res(x);
      chk("counter busy", 64'h0, {repeat_counter_out, busy_out});
      rst_in = 1'b1;
      #1 chk("reset", 64'h0, {sum_register_out, product_out});
      conclude;
   end
endmodule
`default_nettype wire
